// >>> core/eips_top.sv
// apb slave holding the upper-line port selector and routed line outputs
`timescale 1ns/10ps
module eips_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] bank_a_choice,
    input wire logic [7:0] bank_b_choice,
    input wire logic [7:0] bank_c_choice,
    input wire logic [7:0] bank_d_choice,
    input wire logic [7:0] bank_e_choice,
    input wire logic [7:0] bank_f_choice,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] ext_irq_line,
    output eips_pkg::eips_port_type line15_source_port
);
    import eips_pkg::*;
    `include "eips_cfg.svh"

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] ext_irq_port_select_high; // selector register
    logic [31:0] next_ext_irq_port_select_high;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] next_ext_irq_line;
    eips_port_type next_line15_source_port;

    // address decode, used by read and write paths
    function automatic logic hit(input logic [11:0] a);
        hit = (a == `EIPS_SEL_OFFSET);
    endfunction

    // pin that a selector code picks out of the six banks; codes 6 and 7 pick nothing
    function automatic logic route_bit(input logic [2:0] code, input logic [5:0] bank_bits);
        route_bit = 1'b0;
        case (code)
            3'h0: route_bit = bank_bits[0];
            3'h1: route_bit = bank_bits[1];
            3'h2: route_bit = bank_bits[2];
            3'h3: route_bit = bank_bits[3];
            3'h4: route_bit = bank_bits[4];
            3'h5: route_bit = bank_bits[5];
            default: route_bit = 1'b0; // unused codes route nothing
        endcase
    endfunction

    // router instance over interface
    eips_route_if rif ();
    assign rif.sel_word = ext_irq_port_select_high;
    assign rif.bank_pins[0] = bank_a_choice;
    assign rif.bank_pins[1] = bank_b_choice;
    assign rif.bank_pins[2] = bank_c_choice;
    assign rif.bank_pins[3] = bank_d_choice;
    assign rif.bank_pins[4] = bank_e_choice;
    assign rif.bank_pins[5] = bank_f_choice;
    eips_router u_router (
        .rif(rif.router)
    );

    ////////////////////////////////////////////////////////////////////
    // next-state: one-wait-state apb access and register write
    always_comb begin
        next_ext_irq_port_select_high = ext_irq_port_select_high;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            // answer in the cycle after the access phase begins
            next_pready = 1'b1;
            next_pslverr = !hit(paddr);
            if (!pwrite) begin
                next_prdata = hit(paddr) ? ext_irq_port_select_high : 32'h0000_0000;
            end
        end
        if (psel && penable && pready && pwrite && hit(paddr)) begin
            // reserved bits are held at zero whatever software writes
            next_ext_irq_port_select_high = pwdata & `EIPS_FIELD_MASK;
        end
        next_ext_irq_line = rif.lines;
        next_line15_source_port = eips_port_type'(ext_irq_port_select_high[30:28]);
    end

    // registers, frozen while clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_port_select_high <= `EIPS_SEL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ext_irq_line <= 8'h00;
            line15_source_port <= eips_port_a;
        end else if (clk_en) begin
            ext_irq_port_select_high <= next_ext_irq_port_select_high;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ext_irq_line <= next_ext_irq_line;
            line15_source_port <= next_line15_source_port;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_irq_port_select_high & ~`EIPS_FIELD_MASK) == 32'h0)
        else $error("reserved selector bit set");
    chk_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[22:20] == $past(pwdata[22:20]))
        else $error("line 13 selector not written");
    chk_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ext_irq_port_select_high[2:0] == 3'h0 |=>
        ext_irq_line[0] == $past(bank_a_choice[0]))
        else $error("line 8 not routed from port a");
    chk_route_f: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ext_irq_port_select_high[30:28] == 3'h5 |=>
        ext_irq_line[7] == $past(bank_f_choice[7]))
        else $error("line 15 not routed from port f");
    chk_route_c: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ext_irq_port_select_high[26:24] == 3'h2 |=>
        ext_irq_line[6] == $past(bank_c_choice[6]))
        else $error("line 14 not routed from port c");
    chk_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && !pready && !pwrite && hit(paddr) |=>
        pready && prdata == $past(ext_irq_port_select_high))
        else $error("read data mismatch");
    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && pready |=> !pready)
        else $error("ready held too long");
    chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && !pready && !hit(paddr) |=> pready && pslverr)
        else $error("unmapped address not flagged");

    ////////////////////////////////////////////////////////////////////
    // timing that the checks below lean on:
    // - the access phase is taken at the edge where pready is still low
    // - pready and pslverr come back one cycle later, for one cycle
    // - a write lands at the edge where pready is seen high
    // - read data is loaded together with pready and then held
    // - routed lines and the line 15 view trail their inputs by one cycle
    // - while clock enable is low nothing moves, pready included
    // - reserved bits never hold a one, whatever software writes
    // a master that drops penable early is not covered; it still gets pready one cycle later, but its write is not stored
    // an unmapped access still gets an answer, flagged by pslverr
    // codes 6 and 7 are legal to store but route a constant low
    // the routed lines are plain levels; edge detection lives elsewhere
    // all checks are disabled while reset is asserted
    ////////////////////////////////////////////////////////////////////
    // per-field write checks

    // line 15 selector takes the written field
    chk_write_ln15: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[30:28] == $past(pwdata[30:28]))
        else $error("line 15 selector not written");

    // line 14 selector takes the written field
    chk_write_ln14: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[26:24] == $past(pwdata[26:24]))
        else $error("line 14 selector not written");

    // line 12 selector takes the written field
    chk_write_ln12: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[18:16] == $past(pwdata[18:16]))
        else $error("line 12 selector not written");

    // line 11 selector takes the written field
    chk_write_ln11: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[14:12] == $past(pwdata[14:12]))
        else $error("line 11 selector not written");

    // line 10 selector takes the written field
    chk_write_ln10: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[10:8] == $past(pwdata[10:8]))
        else $error("line 10 selector not written");

    // line 9 selector takes the written field
    chk_write_ln9: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[6:4] == $past(pwdata[6:4]))
        else $error("line 9 selector not written");

    // line 8 selector takes the written field
    chk_write_ln8: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && hit(paddr) |=>
        ext_irq_port_select_high[2:0] == $past(pwdata[2:0]))
        else $error("line 8 selector not written");

    ////////////////////////////////////////////////////////////////////
    // per-line routing checks, every code

    // line 8 follows the pin its selector names
    chk_route_ln8: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[0] == $past(route_bit(ext_irq_port_select_high[2:0],
            {bank_f_choice[0], bank_e_choice[0], bank_d_choice[0],
            bank_c_choice[0], bank_b_choice[0], bank_a_choice[0]})))
        else $error("line 8 routed from wrong pin");

    // line 9 follows the pin its selector names
    chk_route_ln9: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[1] == $past(route_bit(ext_irq_port_select_high[6:4],
            {bank_f_choice[1], bank_e_choice[1], bank_d_choice[1],
            bank_c_choice[1], bank_b_choice[1], bank_a_choice[1]})))
        else $error("line 9 routed from wrong pin");

    // line 10 follows the pin its selector names
    chk_route_ln10: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[2] == $past(route_bit(ext_irq_port_select_high[10:8],
            {bank_f_choice[2], bank_e_choice[2], bank_d_choice[2],
            bank_c_choice[2], bank_b_choice[2], bank_a_choice[2]})))
        else $error("line 10 routed from wrong pin");

    // line 11 follows the pin its selector names
    chk_route_ln11: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[3] == $past(route_bit(ext_irq_port_select_high[14:12],
            {bank_f_choice[3], bank_e_choice[3], bank_d_choice[3],
            bank_c_choice[3], bank_b_choice[3], bank_a_choice[3]})))
        else $error("line 11 routed from wrong pin");

    // line 12 follows the pin its selector names
    chk_route_ln12: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[4] == $past(route_bit(ext_irq_port_select_high[18:16],
            {bank_f_choice[4], bank_e_choice[4], bank_d_choice[4],
            bank_c_choice[4], bank_b_choice[4], bank_a_choice[4]})))
        else $error("line 12 routed from wrong pin");

    // line 13 follows the pin its selector names
    chk_route_ln13: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[5] == $past(route_bit(ext_irq_port_select_high[22:20],
            {bank_f_choice[5], bank_e_choice[5], bank_d_choice[5],
            bank_c_choice[5], bank_b_choice[5], bank_a_choice[5]})))
        else $error("line 13 routed from wrong pin");

    // line 14 follows the pin its selector names
    chk_route_ln14: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[6] == $past(route_bit(ext_irq_port_select_high[26:24],
            {bank_f_choice[6], bank_e_choice[6], bank_d_choice[6],
            bank_c_choice[6], bank_b_choice[6], bank_a_choice[6]})))
        else $error("line 14 routed from wrong pin");

    // line 15 follows the pin its selector names
    chk_route_ln15: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> ext_irq_line[7] == $past(route_bit(ext_irq_port_select_high[30:28],
            {bank_f_choice[7], bank_e_choice[7], bank_d_choice[7],
            bank_c_choice[7], bank_b_choice[7], bank_a_choice[7]})))
        else $error("line 15 routed from wrong pin");

    ////////////////////////////////////////////////////////////////////
    // bus and enable checks

    // line 15 view trails the register by one cycle
    chk_line15_view: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> line15_source_port == $past(ext_irq_port_select_high[30:28]))
        else $error("line 15 view out of step");

    // nothing moves while clock enable is low
    chk_enable_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(ext_irq_port_select_high) && $stable(pready) && $stable(ext_irq_line))
        else $error("state moved while frozen");

    // an unmapped write leaves the selectors alone
    chk_bad_write: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && !hit(paddr) |=>
        $stable(ext_irq_port_select_high))
        else $error("unmapped write changed selectors");

    // an unmapped read returns zero
    chk_bad_read: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && !pready && !pwrite && !hit(paddr) |=>
        prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // no answer without an access phase
    chk_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(psel && penable) |=> !pready)
        else $error("ready without access");

    // the error flag only comes with ready
    chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag without ready");

    // read data holds between reads
    chk_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
        else $error("read data changed between reads");
endmodule

// >>> core/eips_cfg.svh
// constants for the external interrupt port selector, upper lines
`ifndef EIPS_CFG_SVH
`define EIPS_CFG_SVH
`define EIPS_SEL_OFFSET 12'h104
`define EIPS_SEL_RESET 32'h0000_0000
`define EIPS_FIELD_PITCH 4
`define EIPS_FIELD_WIDTH 3
`define EIPS_FIRST_LINE 8
`define EIPS_LINE_COUNT 8
`define EIPS_PORT_COUNT 6
`define EIPS_FIELD_MASK 32'h7777_7777
`endif

// >>> core/eips_pkg.sv
// types for the external interrupt port selector
package eips_pkg;
    // selector encoding of the source port
    typedef enum logic [2:0] {
        eips_port_a = 3'h0,
        eips_port_b = 3'h1,
        eips_port_c = 3'h2,
        eips_port_d = 3'h3,
        eips_port_e = 3'h4,
        eips_port_f = 3'h5
    } eips_port_type;
endpackage

// >>> core/eips_route_if.sv
// interface carrying the selector word and pins into the router
`timescale 1ns/10ps
interface eips_route_if;
    logic [31:0] sel_word; // selector register contents
    logic [7:0] bank_pins [6]; // pins 8..15 of each port
    logic [7:0] lines; // routed interrupt lines
    modport regs (output sel_word, output bank_pins, input lines);
    modport router (input sel_word, input bank_pins, output lines);
endinterface

// >>> core/eips_router.sv
// combinational router from port pins to interrupt lines
`timescale 1ns/10ps
module eips_router (
    eips_route_if.router rif
);
    import eips_pkg::*;
    `include "eips_cfg.svh"
    // pick one bank pin per line from its 3-bit field
    always_comb begin
        for (int i = 0; i < `EIPS_LINE_COUNT; i++) begin
            case (rif.sel_word[i*`EIPS_FIELD_PITCH +: `EIPS_FIELD_WIDTH])
                3'h0: rif.lines[i] = rif.bank_pins[0][i];
                3'h1: rif.lines[i] = rif.bank_pins[1][i];
                3'h2: rif.lines[i] = rif.bank_pins[2][i];
                3'h3: rif.lines[i] = rif.bank_pins[3][i];
                3'h4: rif.lines[i] = rif.bank_pins[4][i];
                3'h5: rif.lines[i] = rif.bank_pins[5][i];
                default: rif.lines[i] = 1'b0; // unused codes route nothing
            endcase
        end
    end
endmodule

// >>> verif/ext_irq_port_select_high_bench.sv
// self-checking bench for the upper-line port selector
`timescale 1ns/10ps
`include "eips_cfg.svh"
module ext_irq_port_select_high_bench;
    import eips_pkg::*;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000; // register address
    logic [31:0] pwdata = 32'h0, prdata, q, w, sel, lfsr = 32'h13; // lfsr starts at 19
    logic [7:0] pins [6]; // pins 8..15 of ports a..f
    logic [7:0] ext_irq_line;
    logic pready, pslverr, e;
    eips_port_type line15_source_port;
    int failures = 0, comparisons = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////
    eips_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .bank_a_choice(pins[0]), .bank_b_choice(pins[1]), .bank_c_choice(pins[2]),
        .bank_d_choice(pins[3]), .bank_e_choice(pins[4]), .bank_f_choice(pins[5]),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_line(ext_irq_line), .line15_source_port(line15_source_port));
    always #25 pclk = ~pclk;
    // cut a hang short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    // next random word
    function logic [31:0] rnd();
        for (int i = 0; i < 32; i++) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // routed lines expected for a selector word; codes 6 and 7 give 0
    function logic [7:0] want_lines(input logic [31:0] s);
        logic [7:0] r;
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = s[4*k+:3];
            r[k] = (c < 3'h6) ? pins[c][k] : 1'b0;
        end
        return r;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // new pins, write a selector word, then compare routing and readback
    task route(input logic [31:0] s);
        sel = s & `EIPS_FIELD_MASK;
        for (int i = 0; i < 6; i++) begin
            w = rnd();
            pins[i] <= w[7:0];
        end
        apb(1, `EIPS_SEL_OFFSET, s & `EIPS_FIELD_MASK);
        repeat (2) @(negedge pclk);
        check(ext_irq_line, want_lines(s & `EIPS_FIELD_MASK));
        check(line15_source_port, s[30:28]);
        apb(0, `EIPS_SEL_OFFSET, 32'h0);
        check(q, s & `EIPS_FIELD_MASK);
    endtask
    task results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        foreach (pins[i]) pins[i] = 8'h00;
        for (int r = 0; r < 2; r++) begin
            repeat (16) @(posedge pclk);
            presetn <= 1;
            apb(0, `EIPS_SEL_OFFSET, 32'h0);
            check(q, 32'h0);
            check(ext_irq_line, pins[0]);
            $display("reset test done");
            for (int c = 0; c < 6; c++) route({8{c[3:0]}});
            route(32'hffff_ffff);
            for (int i = 0; i < 12; i++) route(rnd());
            $display("routing test done");
            apb(1, 12'h108, 32'h5555_5555);
            check(e, 1'b1);
            apb(0, `EIPS_SEL_OFFSET, 32'h0);
            check(q, sel);
            $display("unmapped test done");
            q = {24'h0, want_lines(sel)};
            clk_en <= 0;
            foreach (pins[i]) pins[i] <= ~pins[i];
            repeat (3) @(posedge pclk);
            check(ext_irq_line, q);
            clk_en <= 1;
            $display("freeze test done");
            presetn <= 0;
        end
        results();
    end
endmodule
